//--- rtl/anr_pkg.sv
// Constants for the auto-negotiation advertisement register group.
// Assumes Avalon-MM with byte addresses and 32-bit data, one register per word.
package anr_pkg;
    // Register indices, byte address is four times the index
    localparam logic [5:0]  ANR_IDX_CTRL      = 6'h00;
    localparam logic [5:0]  ANR_IDX_ADVERT    = 6'h04;
    localparam logic [5:0]  ANR_IDX_PARTNER   = 6'h05;
    localparam logic [5:0]  ANR_IDX_EXPAN     = 6'h06;
    localparam logic [5:0]  ANR_IDX_ACTIVE    = 6'h1f;
    // Field positions
    localparam int          ANR_BIT_RESTART   = 9;
    localparam int          ANR_BIT_REM_FAULT = 13;
    localparam int          ANR_BIT_100_FULL  = 8;
    localparam int          ANR_BIT_100_HALF  = 7;
    localparam int          ANR_BIT_10_FULL   = 6;
    localparam int          ANR_BIT_10_HALF   = 5;
    localparam int          ANR_SEL_W         = 5;
    // Values and reset values
    localparam logic [4:0]  ANR_SEL_VALUE     = 5'h01;
    localparam logic [15:0] ANR_ADVERT_RESET  = 16'h01e1;
    localparam logic [15:0] ANR_ADVERT_WMASK  = 16'h21e0;
    localparam logic [15:0] ANR_PARTNER_RESET = 16'h0000;
    localparam logic [15:0] ANR_EXPAN_RESET   = 16'h0000;
endpackage : anr_pkg

//--- rtl/anr_capture_reg.sv
// Read-only 16-bit store loaded by the negotiation engine.
// Assumes load and data come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module anr_capture_reg #(
    parameter int          W         = 16,
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    input  wire logic          core_clk_i,
    input  wire logic          srst_i,
    input  wire logic          load_i,
    input  wire logic [W-1:0]  data_i,
    output logic      [W-1:0]  value_o
);
    typedef struct packed {
        logic [W-1:0] value;
    } anr_cap_state_t;

    anr_cap_state_t q;
    anr_cap_state_t d;

    always_comb begin
        d = q;
        if (load_i) begin
            d.value = data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            q.value <= RESET_VAL[W-1:0];
        end else begin
            q <= d;
        end
    end

    assign value_o = q.value;

    cap_load_a : assert property (@(posedge core_clk_i) disable iff (srst_i)
        load_i |=> value_o == $past(data_i))
        else $error("capture register missed a load");
endmodule : anr_capture_reg
`default_nettype wire

//--- rtl/anr_autoneg_regs.sv
// Auto-negotiation advertisement, partner ability and expansion registers.
// Assumes an Avalon-MM master on core_clk_i and a negotiation engine on the same clock.
`timescale 1ns/1ps
`default_nettype none
module anr_autoneg_regs (
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic [15:0] partner_ability_i,
    input  wire logic        partner_load_i,
    input  wire logic [15:0] expansion_i,
    input  wire logic        expansion_load_i,
    output logic      [15:0] advert_page_o,
    output logic             restart_negotiation_o
);
    typedef struct packed {
        logic [15:0] advert;
        logic [15:0] active;
        logic        restart;
        logic        wait_r;
        logic [31:0] rdata;
    } anr_state_t;

    anr_state_t  q;
    anr_state_t  d;
    logic [15:0] partner_val;
    logic [15:0] expan_val;
    logic [5:0]  idx;
    logic [15:0] lane_mask;
    logic [15:0] read_val;
    logic        accept_wr;

    assign idx       = avs_address_i[7:2];
    assign lane_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    // Write lands only at the edge where the master sees waitrequest low
    assign accept_wr = avs_write_i && !q.wait_r;

    anr_capture_reg #(
        .W         (16),
        .RESET_VAL (anr_pkg::ANR_PARTNER_RESET)
    ) u_partner (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .load_i     (partner_load_i),
        .data_i     (partner_ability_i),
        .value_o    (partner_val)
    );

    anr_capture_reg #(
        .W         (16),
        .RESET_VAL (anr_pkg::ANR_EXPAN_RESET)
    ) u_expan (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .load_i     (expansion_load_i),
        .data_i     (expansion_i),
        .value_o    (expan_val)
    );

    // Read mux, unmapped words read as zero
    always_comb begin
        read_val = 16'h0000;
        if (idx == anr_pkg::ANR_IDX_ADVERT) begin
            read_val = {q.advert[15:anr_pkg::ANR_SEL_W], anr_pkg::ANR_SEL_VALUE};
        end else if (idx == anr_pkg::ANR_IDX_PARTNER) begin
            read_val = partner_val;
        end else if (idx == anr_pkg::ANR_IDX_EXPAN) begin
            read_val = expan_val;
        end else if (idx == anr_pkg::ANR_IDX_ACTIVE) begin
            read_val = q.active;
        end else begin
            read_val = 16'h0000;
        end
    end

    always_comb begin
        d         = q;
        d.restart = 1'b0;
        if (q.wait_r) begin
            if (avs_read_i || avs_write_i) begin
                d.wait_r = 1'b0;
                d.rdata  = {16'h0000, read_val};
            end
        end else begin
            d.wait_r = 1'b1;
            if (accept_wr) begin
                if (idx == anr_pkg::ANR_IDX_ADVERT) begin
                    d.advert = (q.advert & ~(anr_pkg::ANR_ADVERT_WMASK & lane_mask))
                             | (avs_writedata_i[15:0] & anr_pkg::ANR_ADVERT_WMASK & lane_mask);
                end else if (idx == anr_pkg::ANR_IDX_CTRL) begin
                    if (avs_byteenable_i[1] && avs_writedata_i[anr_pkg::ANR_BIT_RESTART]) begin
                        d.restart = 1'b1;
                        d.active  = q.advert;
                    end
                end else begin
                    // Read-only and unmapped words drop writes
                    d.advert = q.advert;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            q.advert  <= anr_pkg::ANR_ADVERT_RESET;
            q.active  <= anr_pkg::ANR_ADVERT_RESET;
            q.restart <= 1'b0;
            q.wait_r  <= 1'b1;
            q.rdata   <= 32'h0000_0000;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata_o        = q.rdata;
    assign avs_waitrequest_o     = q.wait_r;
    assign advert_page_o         = q.active;
    assign restart_negotiation_o = q.restart;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    sequence s_restart_req;
        accept_wr && idx == anr_pkg::ANR_IDX_CTRL && avs_byteenable_i[1]
            && avs_writedata_i[anr_pkg::ANR_BIT_RESTART];
    endsequence

    sequence s_advert_wr_hi;
        accept_wr && idx == anr_pkg::ANR_IDX_ADVERT && avs_byteenable_i[1];
    endsequence

    sel_readback_a : assert property (
        (q.wait_r && avs_read_i && idx == anr_pkg::ANR_IDX_ADVERT)
            |=> !avs_waitrequest_o && avs_readdata_o[4:0] == 5'h01)
        else $error("selector did not read back as one");

    sel_constant_a : assert property (
        advert_page_o[4:0] == anr_pkg::ANR_SEL_VALUE)
        else $error("selector field moved");

    reset_abil_a : assert property (
        $past(srst_i) |-> q.advert == 16'h01e1 && advert_page_o == 16'h01e1)
        else $error("advertisement reset value wrong");

    full100_adv_a : assert property (
        s_restart_req |=> restart_negotiation_o
            && advert_page_o[anr_pkg::ANR_BIT_100_FULL] == $past(q.advert[anr_pkg::ANR_BIT_100_FULL]))
        else $error("100 full ability not carried into page");

    restart_page_a : assert property (
        restart_negotiation_o |-> advert_page_o == q.advert ##1 !restart_negotiation_o)
        else $error("restart did not load the edited advertisement");

    page_hold_a : assert property (
        !$stable(advert_page_o) |-> restart_negotiation_o)
        else $error("advertised page changed without restart");

    fault_write_a : assert property (
        s_advert_wr_hi |=> q.advert[anr_pkg::ANR_BIT_REM_FAULT] == $past(avs_writedata_i[anr_pkg::ANR_BIT_REM_FAULT]))
        else $error("remote fault flag write lost");

    partner_ro_a : assert property (
        (accept_wr && idx == anr_pkg::ANR_IDX_PARTNER && !partner_load_i) |=> $stable(partner_val))
        else $error("partner ability changed by a bus write");

    expan_load_a : assert property (
        expansion_load_i |=> expan_val == $past(expansion_i))
        else $error("expansion register missed a load");

    // One wait cycle per request
    wait_pulse_a : assert property (
        (q.wait_r && (avs_read_i || avs_write_i)) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("waitrequest low for other than one cycle");

    // Bus take, lower-lane advertisement write and per-register read conditions
    sequence s_bus_take;
        q.wait_r && (avs_read_i || avs_write_i);
    endsequence

    sequence s_advert_wr_lo;
        accept_wr && idx == anr_pkg::ANR_IDX_ADVERT && avs_byteenable_i[0];
    endsequence

    sequence s_advert_rd;
        q.wait_r && avs_read_i && idx == anr_pkg::ANR_IDX_ADVERT;
    endsequence

    sequence s_partner_rd;
        q.wait_r && avs_read_i && idx == anr_pkg::ANR_IDX_PARTNER;
    endsequence

    sequence s_expan_rd;
        q.wait_r && avs_read_i && idx == anr_pkg::ANR_IDX_EXPAN;
    endsequence

    sequence s_page_rd;
        q.wait_r && avs_read_i && idx == anr_pkg::ANR_IDX_ACTIVE;
    endsequence

    abil_100f_a : assert property (
        s_advert_wr_hi |=> q.advert[anr_pkg::ANR_BIT_100_FULL] == $past(avs_writedata_i[anr_pkg::ANR_BIT_100_FULL]))
        else $error("100 full ability write lost");

    abil_100h_a : assert property (
        s_advert_wr_lo |=> q.advert[anr_pkg::ANR_BIT_100_HALF] == $past(avs_writedata_i[anr_pkg::ANR_BIT_100_HALF]))
        else $error("100 half ability write lost");

    abil_10f_a : assert property (
        s_advert_wr_lo |=> q.advert[anr_pkg::ANR_BIT_10_FULL] == $past(avs_writedata_i[anr_pkg::ANR_BIT_10_FULL]))
        else $error("10 full ability write lost");

    abil_10h_a : assert property (
        s_advert_wr_lo |=> q.advert[anr_pkg::ANR_BIT_10_HALF] == $past(avs_writedata_i[anr_pkg::ANR_BIT_10_HALF]))
        else $error("10 half ability write lost");

    lane_hi_hold_a : assert property (
        (accept_wr && idx == anr_pkg::ANR_IDX_ADVERT && !avs_byteenable_i[1]) |=> q.advert[15:8] == $past(q.advert[15:8]))
        else $error("disabled upper lane was written");

    lane_lo_hold_a : assert property (
        (accept_wr && idx == anr_pkg::ANR_IDX_ADVERT && !avs_byteenable_i[0]) |=> q.advert[7:0] == $past(q.advert[7:0]))
        else $error("disabled lower lane was written");

    advert_rdback_a : assert property (
        s_advert_rd |=> avs_readdata_o[15:5] == $past(q.advert[15:5]))
        else $error("advertisement read back wrong");

    reserved_zero_a : assert property (
        s_advert_rd |=> avs_readdata_o[15:14] == 2'h0 && avs_readdata_o[12:9] == 4'h0)
        else $error("reserved advertisement bits not zero");

    // Upper half of answers zero
    rdata_upper_a : assert property (
        s_bus_take |=> avs_readdata_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");

    partner_rd_a : assert property (
        s_partner_rd |=> avs_readdata_o == {16'h0000, $past(partner_val)})
        else $error("partner ability read wrong");

    expan_rd_a : assert property (
        s_expan_rd |=> avs_readdata_o == {16'h0000, $past(expan_val)})
        else $error("expansion read wrong");

    expan_ro_a : assert property (
        (accept_wr && idx == anr_pkg::ANR_IDX_EXPAN && !expansion_load_i) |=> $stable(expan_val))
        else $error("expansion changed by a bus write");

    page_rdback_a : assert property (
        s_page_rd |=> avs_readdata_o == {16'h0000, $past(advert_page_o)})
        else $error("page in force read wrong");

    advert_wr_page_a : assert property (
        (accept_wr && idx == anr_pkg::ANR_IDX_ADVERT) |=> $stable(advert_page_o))
        else $error("advertisement write reached the page");

    restart_only_a : assert property (
        !(accept_wr && idx == anr_pkg::ANR_IDX_CTRL && avs_byteenable_i[1]
            && avs_writedata_i[anr_pkg::ANR_BIT_RESTART]) |=> !restart_negotiation_o)
        else $error("restart pulse without a restart write");

    restart_lane_a : assert property (
        (accept_wr && idx == anr_pkg::ANR_IDX_CTRL && !avs_byteenable_i[1]) |=> !restart_negotiation_o)
        else $error("restart taken with its lane disabled");

    fault_page_a : assert property (
        s_restart_req |=> advert_page_o[anr_pkg::ANR_BIT_REM_FAULT] == $past(q.advert[anr_pkg::ANR_BIT_REM_FAULT]))
        else $error("remote fault flag not carried into page");

    // Read data held between answers
    rdata_hold_a : assert property (
        (!q.wait_r || (!avs_read_i && !avs_write_i)) |=> $stable(avs_readdata_o))
        else $error("read data changed without an answer");

    // Idle bus keeps waitrequest high
    idle_wait_a : assert property (
        (q.wait_r && !avs_read_i && !avs_write_i) |=> avs_waitrequest_o)
        else $error("waitrequest dropped with no request");
endmodule : anr_autoneg_regs
`default_nettype wire

//--- tb/anr_engine_model.sv
// Negotiation engine stand-in: answers each restart with a partner page.
// Assumes restart pulses arrive on core_clk_i; page values are arbitrary.
`timescale 1ns/1ps
`default_nettype none
module anr_engine_model #(
    parameter logic [15:0] PAGE = 16'h45e1,
    parameter logic [15:0] EXPN = 16'h0003
) (
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic        restart_i,
    output logic      [15:0] partner_o,
    output logic             partner_load_o,
    output logic      [15:0] expansion_o,
    output logic             expansion_load_o
);
    always_ff @(posedge core_clk_i) begin
        partner_load_o   <= restart_i && !srst_i;
        expansion_load_o <= restart_i && !srst_i;
        // Data is meaningless off the load cycle, so show the inverse
        partner_o        <= restart_i ? PAGE : ~PAGE;
        expansion_o      <= restart_i ? EXPN : ~EXPN;
    end
endmodule : anr_engine_model
`default_nettype wire

//--- tb/anr_autoneg_regs_tb_top.sv
// Bench for the advertisement register group: Avalon-MM tasks and checks.
// Assumes one clock; the engine model answers every restart pulse.
`timescale 1ns/1ps
`default_nettype none
module anr_autoneg_regs_tb_top;
    localparam logic [15:0] PAGE = 16'h45e1;
    localparam logic [15:0] EXPN = 16'h0003;
    logic        core_clk_i, srst_i, avs_read_i, avs_write_i;
    logic [7:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rdv;
    logic [3:0]  avs_byteenable_i;
    logic        avs_waitrequest_o, restart_negotiation_o, p_ld, e_ld;
    logic [15:0] p_dat, e_dat, advert_page_o, exp;
    int          err_count = 0;
    int          checks = 0;
    int          nrs = 0;

    anr_autoneg_regs u_anr_autoneg_regs (.core_clk_i(core_clk_i), .srst_i(srst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .partner_ability_i(p_dat), .partner_load_i(p_ld), .expansion_i(e_dat),
        .expansion_load_i(e_ld), .advert_page_o(advert_page_o),
        .restart_negotiation_o(restart_negotiation_o));
    anr_engine_model #(.PAGE(PAGE), .EXPN(EXPN)) u_anr_engine_model (.core_clk_i(core_clk_i),
        .srst_i(srst_i), .restart_i(restart_negotiation_o), .partner_o(p_dat),
        .partner_load_o(p_ld), .expansion_o(e_dat), .expansion_load_o(e_ld));

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) if (restart_negotiation_o === 1'b1) nrs++;

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask : chk
    // Holds the request until waitrequest is sampled low, then idles a cycle
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        if (w) avs_write_i <= 1'b1;
        else avs_read_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) chk(32'h1, 32'h0);
        rdv = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : acc
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        acc(1'b0, a, 32'h0, 4'hf);
        chk(rdv, want);
    endtask : rd
    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results

    initial begin
        #20000;
        err_count++;
        results();
    end
    initial begin
        {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, avs_byteenable_i} = '0;
        srst_i = 1'b1;
        repeat (4) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        rd(8'h10, 32'h01e1);
        rd(8'h14, 32'h0);
        rd(8'h18, 32'h0);
        rd(8'h7c, 32'h01e1);
        rd(8'h40, 32'h0);
        chk({16'h0000, advert_page_o}, 32'h01e1);
        $display("test reset done");
        acc(1'b1, 8'h10, 32'hffff, 4'h3);
        rd(8'h10, 32'h21e1);
        chk({16'h0000, advert_page_o}, 32'h01e1);
        acc(1'b1, 8'h14, 32'hffff, 4'h3);
        rd(8'h14, 32'h0);
        acc(1'b1, 8'h18, 32'hffff, 4'h3);
        rd(8'h18, 32'h0);
        acc(1'b1, 8'h10, 32'h0, 4'h1);
        rd(8'h10, 32'h2101);
        $display("test access done");
        for (int b = 5; b <= 8; b++) begin
            exp = 16'h01e1 & ~(16'h1 << b);
            acc(1'b1, 8'h10, {16'h0, exp}, 4'h3);
            chk({16'h0000, advert_page_o}, (b == 5) ? 32'h01e1 : 32'h01e1 & ~(32'h1 << (b - 1)));
            acc(1'b1, 8'h00, 32'h0200, 4'h3);
            @(posedge core_clk_i);
            chk(nrs, b - 4);
            chk({16'h0000, advert_page_o}, {16'h0000, exp});
            rd(8'h14, {16'h0000, PAGE});
            rd(8'h18, {16'h0000, EXPN});
        end
        acc(1'b1, 8'h00, 32'h0200, 4'h1);
        @(posedge core_clk_i);
        chk(nrs, 4);
        $display("test restart done");
        results();
    end
endmodule : anr_autoneg_regs_tb_top
`default_nettype wire
